// File: sce_engine.sv
`timescale 1ns/1ps

module sce_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Fill side.
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side.
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } sce_fifo_state_t;

    sce_fifo_state_t st_reg;
    sce_fifo_state_t st_next;
    logic do_push;
    logic do_pop;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("sce_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    assign o_in_ready = (st_reg.count != (AW + 1)'(DEPTH));
    assign o_out_valid = (st_reg.count != '0);
    assign o_out_data = st_reg.mem[st_reg.rd_ptr];
    assign do_push = i_in_valid && o_in_ready;
    assign do_pop = o_out_valid && i_out_ready;

    always_comb begin
        st_next = st_reg;
        if (do_push) begin
            st_next.mem[st_reg.wr_ptr] = i_in_data;
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (do_pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
        st_next.count = st_reg.count + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
        if (i_rst) begin
            st_next = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        st_reg <= st_next;
    end
endmodule // sce_fifo

module sce_engine
    import sce_pkg::*;
#(
    parameter int P_CLKS_PER_BIT = sce_pkg::CLKS_PER_BIT,
    parameter int P_DATA_TIMEOUT = sce_pkg::DATA_TIMEOUT_CLKS
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Serial link pins.
    input wire logic i_uart_rx,
    output logic o_uart_tx,
    // Conditioning path.
    input wire logic [sce_pkg::TEMP_W-1:0] i_temp_code,
    input wire logic [9:0] i_cond_value,
    output logic [9:0] o_output_value,
    output logic o_fault,
    // Clock trim and working settings.
    output logic o_booting,
    output logic [7:0] o_clock_trim,
    output sce_pkg::sce_working_t o_working
);
    import sce_pkg::*;

    typedef struct packed {
        logic [NV_DEPTH-1:0][7:0] nv;
        logic [RAM_DEPTH-1:0][7:0] ram;
        sce_state_t state;
        sce_state_t ret_state;
        logic [7:0] push_byte;
        logic [1:0] cmd_op;
        logic [5:0] cmd_addr;
        logic [5:0] idx;
        logic [7:0] sum;
        logic [23:0] tmo;
        logic rx_s1;
        logic rx_s2;
        logic rx_busy;
        logic [15:0] rx_cnt;
        logic [3:0] rx_idx;
        logic [7:0] rx_shift;
        logic rx_valid;
        sce_rx_t rx_out;
        logic tx_busy;
        logic [15:0] tx_cnt;
        logic [3:0] tx_idx;
        logic [9:0] tx_shift;
        logic tx_line;
        logic booting;
        logic fault;
        logic [7:0] trim;
        logic [9:0] out_val;
        sce_working_t work;
    } sce_engine_state_t;

    sce_engine_state_t st_reg;
    sce_engine_state_t st_next;
    logic push_valid;
    logic [7:0] push_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic tx_pop;
    logic [7:0] final_sum;

    initial begin
        if (P_CLKS_PER_BIT < 4 || P_CLKS_PER_BIT > 65535) begin
            $error("sce_engine: P_CLKS_PER_BIT out of range");
        end
        if (P_DATA_TIMEOUT < 2 || P_DATA_TIMEOUT > 16777215) begin
            $error("sce_engine: P_DATA_TIMEOUT out of range");
        end
    end

    // Sign-magnitude to two's complement, so downstream arithmetic needs no sign handling.
    function automatic logic [12:0] sm_to_signed(input logic [11:0] v);
        logic [12:0] mag;
        mag = {2'h0, v[10:0]};
        return v[11] ? 13'(-mag) : mag;
    endfunction

    function automatic logic [7:0] band_trim(input logic [7:0] t, input sce_working_t w);
        if (t < w.first_band_threshold) begin
            return w.low_band_clock_trim;
        end else if (t < w.second_band_threshold) begin
            return w.mid_band_clock_trim;
        end
        return w.high_band_clock_trim;
    endfunction

    assign push_valid = (st_reg.state == SCE_PUSH) || (st_reg.state == SCE_ACK1)
        || (st_reg.state == SCE_ACK2) || (st_reg.state == SCE_RST_ACK);
    assign push_data = (st_reg.state == SCE_PUSH) ? st_reg.push_byte : ACK_BYTE;
    assign tx_pop = !st_reg.tx_busy;
    assign final_sum = st_reg.sum + st_reg.nv[st_reg.idx];

    sce_fifo #(
        .WIDTH(8),
        .DEPTH(TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(push_valid),
        .i_in_data(push_data),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out_data),
        .i_out_ready(tx_pop)
    );

    always_comb begin
        st_next = st_reg;
        st_next.rx_valid = 1'b0;
        // Receiver, 8N1 sampled mid-bit after a two-stage synchroniser.
        st_next.rx_s1 = i_uart_rx;
        st_next.rx_s2 = st_reg.rx_s1;
        if (!st_reg.rx_busy) begin
            if (!st_reg.rx_s2) begin
                st_next.rx_busy = 1'b1;
                st_next.rx_idx = '0;
                st_next.rx_cnt = 16'(P_CLKS_PER_BIT / 2);
            end
        end else if (st_reg.rx_cnt != '0) begin
            st_next.rx_cnt = st_reg.rx_cnt - 1'b1;
        end else begin
            st_next.rx_cnt = 16'(P_CLKS_PER_BIT - 1);
            st_next.rx_idx = st_reg.rx_idx + 1'b1;
            if (st_reg.rx_idx == '0) begin
                st_next.rx_busy = !st_reg.rx_s2;
            end else if (st_reg.rx_idx == 4'(UART_FRAME_BITS - 1)) begin
                st_next.rx_busy = 1'b0;
                st_next.rx_valid = 1'b1;
                st_next.rx_out.data = st_reg.rx_shift;
                st_next.rx_out.err = !st_reg.rx_s2;
            end else begin
                st_next.rx_shift = {st_reg.rx_s2, st_reg.rx_shift[7:1]};
            end
        end
        // Transmitter: start bit, data LSB first, stop bit.
        if (!st_reg.tx_busy) begin
            st_next.tx_line = 1'b1;
            if (fifo_out_valid) begin
                st_next.tx_busy = 1'b1;
                st_next.tx_shift = {1'b1, fifo_out_data, 1'b0};
                st_next.tx_idx = '0;
                st_next.tx_cnt = 16'(P_CLKS_PER_BIT - 1);
                st_next.tx_line = 1'b0;
            end
        end else if (st_reg.tx_cnt != '0) begin
            st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
        end else if (st_reg.tx_idx == 4'(UART_FRAME_BITS - 1)) begin
            st_next.tx_busy = 1'b0;
            st_next.tx_line = 1'b1;
        end else begin
            st_next.tx_cnt = 16'(P_CLKS_PER_BIT - 1);
            st_next.tx_idx = st_reg.tx_idx + 1'b1;
            st_next.tx_shift = {1'b1, st_reg.tx_shift[9:1]};
            st_next.tx_line = st_reg.tx_shift[1];
        end
        // Command engine.
        case (st_reg.state)
            SCE_INIT: begin
                st_next.sum = final_sum;
                st_next.idx = st_reg.idx + 1'b1;
                if (st_reg.idx == NV_LAST) begin
                    st_next.fault = st_reg.nv[NV_MODE][CKSUM_EN_BIT]
                        && (final_sum != CKSUM_TARGET);
                    st_next.work.mode = st_reg.nv[NV_MODE];
                    st_next.work.coarse = st_reg.nv[NV_COARSE];
                    st_next.work.fixed_gain = {st_reg.nv[NV_FIXED_HI][HI_UPPER_LSB +: 2],
                        st_reg.nv[NV_GAIN_LO]};
                    st_next.work.fixed_offset = {st_reg.nv[NV_FIXED_HI][HI_LOWER_LSB +: 2],
                        st_reg.nv[NV_OFS_LO]};
                    st_next.work.gain_tc1 = sm_to_signed({st_reg.nv[NV_TC1_HI][HI_UPPER_LSB +: 4],
                        st_reg.nv[NV_GTC1_LO]});
                    st_next.work.offset_tc1 = sm_to_signed({st_reg.nv[NV_TC1_HI][HI_LOWER_LSB +: 4],
                        st_reg.nv[NV_OTC1_LO]});
                    st_next.work.first_band_threshold = st_reg.nv[NV_THR1];
                    st_next.work.second_band_threshold = st_reg.nv[NV_THR2];
                    st_next.work.low_band_clock_trim = st_reg.nv[NV_LOW_TRIM];
                    st_next.work.mid_band_clock_trim = st_reg.nv[NV_MID_TRIM];
                    st_next.work.high_band_clock_trim = st_reg.nv[NV_HIGH_TRIM];
                    st_next.work.fault_value = {st_reg.nv[NV_FAULT_HI][1:0],
                        st_reg.nv[NV_FAULT_LO]};
                    st_next.ram[RAM_GTC1_LO] = st_reg.nv[NV_GTC1_LO];
                    st_next.ram[RAM_OTC1_LO] = st_reg.nv[NV_OTC1_LO];
                    st_next.ram[RAM_TC1_HI] = st_reg.nv[NV_TC1_HI];
                    st_next.booting = 1'b0;
                    st_next.state = SCE_IDLE;
                end
            end
            SCE_IDLE: begin
                if (st_reg.rx_valid && !st_reg.rx_out.err) begin
                    st_next.cmd_op = st_reg.rx_out.data[7:6];
                    st_next.cmd_addr = st_reg.rx_out.data[5:0];
                    st_next.state = SCE_PUSH;
                    st_next.ret_state = SCE_IDLE;
                    st_next.tmo = '0;
                    case (st_reg.rx_out.data[7:6])
                        OP_RAM_RD: begin
                            st_next.push_byte = st_reg.ram[st_reg.rx_out.data[5:0]];
                        end
                        OP_NV_RD: begin
                            if (st_reg.rx_out.data[5:0] == ADDR_SOFT_RESET) begin
                                st_next.state = SCE_RST_ACK;
                            end else if (st_reg.rx_out.data[5:0] <= NV_LAST) begin
                                st_next.push_byte = st_reg.nv[st_reg.rx_out.data[5:0]];
                            end else begin
                                st_next.push_byte = 8'h00;
                            end
                        end
                        default: begin
                            st_next.push_byte = st_reg.rx_out.data;
                            st_next.ret_state = SCE_WAIT_DATA;
                        end
                    endcase
                end
            end
            SCE_PUSH: begin
                if (fifo_in_ready) begin
                    st_next.state = st_reg.ret_state;
                end
            end
            SCE_WAIT_DATA: begin
                st_next.tmo = st_reg.tmo + 1'b1;
                if (st_reg.rx_valid) begin
                    st_next.state = SCE_IDLE;
                    if (!st_reg.rx_out.err) begin
                        if (st_reg.cmd_op == OP_RAM_WR) begin
                            st_next.ram[st_reg.cmd_addr] = st_reg.rx_out.data;
                            st_next.state = SCE_ACK1;
                        end else if (st_reg.cmd_addr <= NV_LAST) begin
                            st_next.nv[st_reg.cmd_addr] = st_reg.rx_out.data;
                            st_next.state = SCE_ACK1;
                        end
                    end
                end else if (st_reg.tmo == 24'(P_DATA_TIMEOUT - 1)) begin
                    st_next.state = SCE_IDLE;
                end
            end
            SCE_ACK1: begin
                if (fifo_in_ready) begin
                    st_next.state = SCE_ACK2;
                end
            end
            SCE_ACK2: begin
                if (fifo_in_ready) begin
                    st_next.state = SCE_IDLE;
                end
            end
            SCE_RST_ACK: begin
                if (fifo_in_ready) begin
                    st_next.state = SCE_RST_DRAIN;
                end
            end
            SCE_RST_DRAIN: begin
                // Wait for the confirmation byte to leave the pin before reset wipes the sender.
                if (!fifo_out_valid && !st_reg.tx_busy) begin
                    st_next = '0;
                    st_next.nv = st_reg.nv;
                    st_next.rx_s1 = 1'b1;
                    st_next.rx_s2 = 1'b1;
                    st_next.tx_line = 1'b1;
                    st_next.booting = 1'b1;
                    st_next.state = SCE_INIT;
                end
            end
            default: begin
                st_next.state = SCE_IDLE;
            end
        endcase
        // The 10-bit temperature code is kept in two RAM bytes and overrides host writes there.
        st_next.ram[RAM_TEMP_LO] = i_temp_code[7:0];
        st_next.ram[RAM_TEMP_HI] = 8'(i_temp_code[TEMP_W-1:8]);
        st_next.trim = st_reg.booting ? st_reg.nv[NV_BOOT_TRIM]
            : band_trim(i_temp_code[TEMP_W-1 -: 8], st_reg.work);
        st_next.out_val = st_reg.fault ? st_reg.work.fault_value : i_cond_value;
        // Power-up reset models a blank part: nonvolatile contents start at zero.
        if (i_rst) begin
            st_next = '0;
            st_next.rx_s1 = 1'b1;
            st_next.rx_s2 = 1'b1;
            st_next.tx_line = 1'b1;
            st_next.booting = 1'b1;
            st_next.state = SCE_INIT;
        end
    end

    always_ff @(posedge i_clk) begin
        st_reg <= st_next;
    end

    assign o_uart_tx = st_reg.tx_line;
    assign o_output_value = st_reg.out_val;
    assign o_fault = st_reg.fault;
    assign o_booting = st_reg.booting;
    assign o_clock_trim = st_reg.trim;
    assign o_working = st_reg.work;

    logic cmd_in;
    assign cmd_in = st_reg.state == SCE_IDLE && st_reg.rx_valid && !st_reg.rx_out.err;

    property p_reset_cmd;
        @(posedge i_clk) disable iff (i_rst)
        cmd_in && st_reg.rx_out.data == {OP_NV_RD, ADDR_SOFT_RESET} |=> st_reg.state == SCE_RST_ACK;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset command not taken");

    property p_echo;
        @(posedge i_clk) disable iff (i_rst)
        cmd_in && !st_reg.rx_out.data[7] |=> st_reg.state == SCE_PUSH
            && st_reg.push_byte == $past(st_reg.rx_out.data) && st_reg.ret_state == SCE_WAIT_DATA;
    endproperty
    a_echo: assert property (p_echo) else $error("write command not echoed");

    property p_read_reply;
        @(posedge i_clk) disable iff (i_rst)
        cmd_in && st_reg.rx_out.data[7:6] == OP_RAM_RD
            |=> st_reg.push_byte == $past(st_reg.ram[st_reg.rx_out.data[5:0]]);
    endproperty
    a_read_reply: assert property (p_read_reply) else $error("wrong read reply");

    property p_ack_pair;
        @(posedge i_clk) disable iff (i_rst)
        st_reg.state == SCE_ACK1 && fifo_in_ready |=> st_reg.state == SCE_ACK2 && push_data == ACK_BYTE;
    endproperty
    a_ack_pair: assert property (p_ack_pair) else $error("second ack byte missing");

    property p_bad_data;
        @(posedge i_clk) disable iff (i_rst)
        st_reg.state == SCE_WAIT_DATA && st_reg.rx_valid && st_reg.rx_out.err
            |=> st_reg.state == SCE_IDLE && $stable(st_reg.nv);
    endproperty
    a_bad_data: assert property (p_bad_data) else $error("broken data byte stored");

    property p_boot_trim;
        @(posedge i_clk) disable iff (i_rst)
        st_reg.booting |=> o_clock_trim == $past(st_reg.nv[NV_BOOT_TRIM]);
    endproperty
    a_boot_trim: assert property (p_boot_trim) else $error("boot trim not applied");

    property p_checksum;
        @(posedge i_clk) disable iff (i_rst)
        st_reg.state == SCE_INIT && st_reg.idx == NV_LAST
            |=> o_fault == ($past(st_reg.nv[NV_MODE][CKSUM_EN_BIT]) && $past(final_sum) != CKSUM_TARGET);
    endproperty
    a_checksum: assert property (p_checksum) else $error("checksum verdict wrong");

    property p_fault_out;
        @(posedge i_clk) disable iff (i_rst)
        o_fault ##1 o_fault |-> o_output_value == $past(st_reg.work.fault_value);
    endproperty
    a_fault_out: assert property (p_fault_out) else $error("fault value not driven");

    property p_work_stable;
        @(posedge i_clk) disable iff (i_rst)
        st_reg.state == SCE_IDLE |=> $stable(o_working);
    endproperty
    a_work_stable: assert property (p_work_stable) else $error("settings changed outside init");

    c_write_acked: cover property (@(posedge i_clk) st_reg.state == SCE_ACK2 && fifo_in_ready);
    c_soft_reset: cover property (@(posedge i_clk) st_reg.state == SCE_RST_DRAIN ##1 st_reg.state == SCE_INIT);
    c_cksum_fail: cover property (@(posedge i_clk) $rose(o_fault));
endmodule // sce_engine

// File: sce_host_model.sv
`timescale 1ns/1ps
module sce_host_model #(
    parameter int P_BIT = 16
) (
    // Clock.
    input wire logic i_clk,
    // Serial lines.
    input wire logic i_dev_tx,
    output logic o_dev_rx
);
    // Cleared by the bench to send one frame whose stop bit is low for a full bit.
    logic stop_bit = 1'b1;
    initial o_dev_rx = 1'b1;
    // The stop bit is cut short so that an answer starting right after it is not missed.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        @(posedge i_clk);
        f = {stop_bit, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_dev_rx <= f[i];
            repeat ((i == 9 && stop_bit) ? 4 : P_BIT) @(posedge i_clk);
        end
        o_dev_rx <= 1'b1;
    endtask
    task automatic recv(output logic [7:0] b);
        while (i_dev_tx !== 1'b0) @(posedge i_clk);
        repeat (P_BIT / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (P_BIT) @(posedge i_clk);
            b[i] = i_dev_tx;
        end
        repeat (P_BIT) @(posedge i_clk);
    endtask
endmodule // sce_host_model

// File: sce_pkg.sv
package sce_pkg;

    // Clock and serial timing.
    localparam int CLK_HZ = 125_000_000;
    localparam int BAUD_RATE = 9600;
    localparam int CLKS_PER_BIT = CLK_HZ / BAUD_RATE;
    localparam int DATA_TIMEOUT_BITS = 40;
    localparam int DATA_TIMEOUT_CLKS = CLKS_PER_BIT * DATA_TIMEOUT_BITS;
    localparam int UART_FRAME_BITS = 10;
    localparam int TX_FIFO_DEPTH = 8;

    // Command byte layout.
    localparam logic [1:0] OP_RAM_RD = 2'h3;
    localparam logic [1:0] OP_NV_RD = 2'h2;
    localparam logic [1:0] OP_NV_WR = 2'h1;
    localparam logic [1:0] OP_RAM_WR = 2'h0;
    localparam logic [5:0] ADDR_SOFT_RESET = 6'h3F;
    localparam logic [7:0] ACK_BYTE = 8'hBC;

    // Memory sizes and checksum.
    localparam int NV_DEPTH = 48;
    localparam int RAM_DEPTH = 64;
    localparam logic [5:0] NV_LAST = 6'h2F;
    localparam logic [7:0] CKSUM_TARGET = 8'hFF;
    localparam int CKSUM_EN_BIT = 7;

    // Nonvolatile map.
    localparam logic [5:0] NV_MODE = 6'h00;
    localparam logic [5:0] NV_BOOT_TRIM = 6'h01;
    localparam logic [5:0] NV_COARSE = 6'h02;
    localparam logic [5:0] NV_GAIN_LO = 6'h03;
    localparam logic [5:0] NV_OFS_LO = 6'h04;
    localparam logic [5:0] NV_GTC1_LO = 6'h05;
    localparam logic [5:0] NV_OTC1_LO = 6'h06;
    localparam logic [5:0] NV_FIXED_HI = 6'h11;
    localparam logic [5:0] NV_TC1_HI = 6'h12;
    localparam logic [5:0] NV_LOW_TRIM = 6'h20;
    localparam logic [5:0] NV_MID_TRIM = 6'h21;
    localparam logic [5:0] NV_HIGH_TRIM = 6'h22;
    localparam logic [5:0] NV_THR1 = 6'h23;
    localparam logic [5:0] NV_THR2 = 6'h24;
    localparam logic [5:0] NV_FAULT_HI = 6'h28;
    localparam logic [5:0] NV_FAULT_LO = 6'h29;
    localparam int HI_UPPER_LSB = 4;
    localparam int HI_LOWER_LSB = 0;

    // RAM map.
    localparam logic [5:0] RAM_TEMP_LO = 6'h00;
    localparam logic [5:0] RAM_TEMP_HI = 6'h01;
    localparam logic [5:0] RAM_GTC1_LO = 6'h02;
    localparam logic [5:0] RAM_OTC1_LO = 6'h03;
    localparam logic [5:0] RAM_TC1_HI = 6'h04;

    localparam int TEMP_W = 10;

    typedef enum logic [2:0] {
        SCE_INIT = 3'h0,
        SCE_IDLE = 3'h1,
        SCE_PUSH = 3'h2,
        SCE_WAIT_DATA = 3'h3,
        SCE_ACK1 = 3'h4,
        SCE_ACK2 = 3'h5,
        SCE_RST_ACK = 3'h6,
        SCE_RST_DRAIN = 3'h7
    } sce_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic err;
    } sce_rx_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] coarse;
        logic [9:0] fixed_gain;
        logic [9:0] fixed_offset;
        logic [12:0] gain_tc1;
        logic [12:0] offset_tc1;
        logic [7:0] first_band_threshold;
        logic [7:0] second_band_threshold;
        logic [7:0] low_band_clock_trim;
        logic [7:0] mid_band_clock_trim;
        logic [7:0] high_band_clock_trim;
        logic [9:0] fault_value;
    } sce_working_t;

endpackage

// File: test_serial_config_command_engine.sv
`timescale 1ns/1ps
module test_serial_config_command_engine;
    import sce_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic uart_rx;
    logic uart_tx;
    logic [9:0] cond = 10'h155;
    logic [9:0] temp = 10'h000;
    logic [9:0] out_value;
    logic fault;
    logic booting;
    logic [7:0] trim;
    logic [7:0] rb;
    sce_working_t working;
    int err_total = 0;
    int n_compared = 0;
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    sce_engine #(.P_CLKS_PER_BIT(16), .P_DATA_TIMEOUT(2000)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
        .i_uart_rx(uart_rx), .o_uart_tx(uart_tx), .i_temp_code(temp), .i_cond_value(cond),
        .o_output_value(out_value), .o_fault(fault), .o_booting(booting),
        .o_clock_trim(trim), .o_working(working));
    sce_host_model #(.P_BIT(16)) host_u (.i_clk(i_clk), .i_dev_tx(uart_tx), .o_dev_rx(uart_rx));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        host_u.send(cmd);
        host_u.recv(rb);
        check(rb, cmd);
        host_u.send(d);
        host_u.recv(rb);
        check(rb, ACK_BYTE);
        host_u.recv(rb);
        check(rb, ACK_BYTE);
    endtask
    task automatic band(input logic [9:0] t, input logic [7:0] exp_trim);
        @(posedge i_clk);
        temp <= t;
        repeat (3) @(posedge i_clk);
        #1 check(trim, exp_trim);
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        host_u.send(cmd);
        host_u.recv(rb);
        check(rb, exp);
    endtask
    // Two edges of margin let the registered trim settle after boot starts.
    task automatic boot(input logic [7:0] exp_trim);
        for (int n = 0; n < 200 && booting !== 1'b1; n++) @(posedge i_clk);
        repeat (2) @(posedge i_clk);
        #1 check(trim, exp_trim);
        for (int n = 0; n < 200 && booting !== 1'b0; n++) @(posedge i_clk);
        repeat (2) @(posedge i_clk);
        #1 check(booting, 1'b0);
    endtask
    task automatic soft_reset();
        host_u.send(8'hBF);
        host_u.recv(rb);
        check(rb, ACK_BYTE);
        boot(8'h5A);
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        boot(8'h00);
        check(fault, 1'b0);
        wr(8'h41, 8'h5A);
        rd(8'h81, 8'h5A);
        wr(8'h40, 8'h80);
        wr(8'h69, 8'h33);
        check(working.mode, 8'h00);
        $display("test write and read done");
        soft_reset();
        check(working.mode, 8'h80);
        check(fault, 1'b1);
        check(out_value, 10'h033);
        // Byte 47 balances 80h + 5Ah + 33h to a sum of FFh.
        wr(8'h6F, 8'hF2);
        soft_reset();
        check(fault, 1'b0);
        check(out_value, cond);
        @(posedge i_clk);
        cond <= 10'h2AA;
        repeat (2) @(posedge i_clk);
        #1 check(out_value, 10'h2AA);
        $display("test checksum done");
        host_u.send(8'h42);
        host_u.recv(rb);
        check(rb, 8'h42);
        repeat (2100) @(posedge i_clk);
        rd(8'h82, 8'h00);
        $display("test data timeout done");
        host_u.send(8'h43);
        host_u.recv(rb);
        check(rb, 8'h43);
        host_u.stop_bit = 1'b0;
        host_u.send(8'h99);
        host_u.stop_bit = 1'b1;
        repeat (40) @(posedge i_clk);
        rd(8'h83, 8'h00);
        $display("test framing error done");
        wr(8'h0A, 8'hC3);
        rd(8'hCA, 8'hC3);
        $display("test ram access done");
        wr(8'h52, 8'hC4);
        wr(8'h60, 8'h11);
        wr(8'h61, 8'h22);
        wr(8'h62, 8'h33);
        wr(8'h63, 8'h40);
        wr(8'h64, 8'h80);
        soft_reset();
        check(fault, 1'b1);
        check(working.gain_tc1, 16'h1C00);
        check(working.offset_tc1, 16'h0400);
        rd(8'hC4, 8'hC4);
        band(10'h0FC, 8'h11);
        band(10'h100, 8'h22);
        band(10'h1FC, 8'h22);
        band(10'h2FF, 8'h33);
        rd(8'hC0, 8'hFF);
        rd(8'hC1, 8'h02);
        $display("test clock trim bands done");
        final_report();
    end
    initial begin
        repeat (60000) @(posedge i_clk);
        err_total++;
        final_report();
    end
endmodule // test_serial_config_command_engine
